// >>> rtl/ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SSP_ADDR_TX_STATUS_CONTROL 8'h00
`define SSP_ADDR_RX_STATUS_CONTROL 8'h04
`define SSP_ADDR_TX_BUFFER 8'h08
`define SSP_ADDR_RX_BUFFER 8'h0c
`define SSP_ADDR_IRQ_FLAGS 8'h10
`define SSP_ADDR_IRQ_ENABLES 8'h14
`define SSP_ADDR_IRQ_PRIORITY 8'h18
`define SSP_ADDR_BAUD_DIVISOR 8'h1c
`define SSP_ADDR_INT_CONTROL 8'h20

// ----------------------------------------
// Transmit status/control fields
// ----------------------------------------
`define SSP_TX_CLOCK_SOURCE 7
`define SSP_TX_NINTH_EN 6
`define SSP_TX_ENABLE 5
`define SSP_TX_SYNC 4
`define SSP_TX_HIGH_SPEED 2
`define SSP_TX_SHIFT_EMPTY 1
`define SSP_TX_NINTH_VALUE 0

// ----------------------------------------
// Receive status/control fields
// ----------------------------------------
`define SSP_RX_PORT_ENABLE 7
`define SSP_RX_NINTH_EN 6
`define SSP_RX_SINGLE 5
`define SSP_RX_CONTINUOUS 4
`define SSP_RX_ADDR_DETECT 3
`define SSP_RX_FRAMING_ERR 2
`define SSP_RX_OVERRUN_ERR 1
`define SSP_RX_NINTH_VALUE 0

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define SSP_IRQ_RX_COMPLETE 5
`define SSP_IRQ_TX_EMPTY 4
`define SSP_INT_GLOBAL 7
`define SSP_INT_PERIPHERAL 6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SSP_RESET_BYTE 8'h00
`define SSP_CLK_NS 50
`define SSP_LINK_HALF_NS 400
`define SSP_LINK_HALF_CYC ((`SSP_LINK_HALF_NS) / (`SSP_CLK_NS))

`endif

// >>> rtl/ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_MST_IDLE,
    SSP_MST_LOW,
    SSP_MST_HIGH
  } ssp_mst_state_t;

  // Bits in one word on the data line
  function automatic logic [3:0] ssp_word_len(input logic nine);
    return nine ? 4'h9 : 4'h8;
  endfunction

endpackage

// >>> rtl/ssp_link_if.sv
`timescale 1ns/1ns
interface ssp_link_if;
  logic shift_clock_pin;
  logic dev_dt_o;
  logic dev_dt_oe;
  logic mst_dt_o;
  logic mst_dt_oe;
  logic serial_data_pin;

  // Weak pull-up when nobody drives the data line
  assign serial_data_pin = dev_dt_oe ? dev_dt_o : (mst_dt_oe ? mst_dt_o : 1'b1);

  modport dev (
    input shift_clock_pin,
    input serial_data_pin,
    output dev_dt_o,
    output dev_dt_oe
  );

  modport mst (
    output shift_clock_pin,
    input serial_data_pin,
    output mst_dt_o,
    output mst_dt_oe
  );
endinterface

// >>> rtl/ssp_slave_dev.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "ssp_defs.svh"
module ssp_slave_dev (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power_mode,
  output logic wake_request,
  output logic irq_vector_request,
  ssp_link_if.dev link
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic clock_source_select_r, tx_ninth_bit_enable_r, tx_enable_r, sync_r;
  logic high_speed_baud_select_r, tx_ninth_bit_value_r;
  logic port_enable_r, rx_ninth_bit_enable_r, single_rx_enable_r;
  logic continuous_rx_enable_r, address_detect_enable_r;
  logic overrun_error_flag_r, rx_ninth_bit_value_r;
  logic [7:0] serial_tx_buffer_r, serial_rx_buffer_r;
  logic [7:0] irq_priority_r, baud_divisor_r;
  logic tx_buffer_full_r, tx_buffer_empty_flag_r, rx_complete_flag_r;
  logic tx_irq_enable_r, rx_irq_enable_r, global_irq_enable_r, peripheral_irq_enable_r;
  logic [8:0] tx_shift_register_r, rx_shift_register_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic tx_busy_r;
  logic [2:0] ck_q_r, dt_q_r;
  logic ck_lvl_r, dt_lvl_r;
  logic [31:0] rd_data;
  logic wr_en, rd_en, addr_ok, ck_fall, tx_on, rx_on, tx_load, rx_done;
  logic [8:0] rx_next;

  // ----------------------------------------
  // APB slave: one wait-free access phase
  // ----------------------------------------
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & pready & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    unique case (paddr)
      `SSP_ADDR_TX_STATUS_CONTROL: begin
        rd_data[7:0] = {clock_source_select_r, tx_ninth_bit_enable_r, tx_enable_r, sync_r,
          1'b0, high_speed_baud_select_r, ~tx_busy_r, tx_ninth_bit_value_r};
      end
      `SSP_ADDR_RX_STATUS_CONTROL: begin
        rd_data[7:0] = {port_enable_r, rx_ninth_bit_enable_r, single_rx_enable_r,
          continuous_rx_enable_r, address_detect_enable_r, 1'b0, overrun_error_flag_r,
          rx_ninth_bit_value_r};
      end
      `SSP_ADDR_TX_BUFFER: rd_data[7:0] = serial_tx_buffer_r;
      `SSP_ADDR_RX_BUFFER: rd_data[7:0] = serial_rx_buffer_r;
      `SSP_ADDR_IRQ_FLAGS: begin
        rd_data[`SSP_IRQ_RX_COMPLETE] = rx_complete_flag_r;
        rd_data[`SSP_IRQ_TX_EMPTY] = tx_buffer_empty_flag_r;
      end
      `SSP_ADDR_IRQ_ENABLES: begin
        rd_data[`SSP_IRQ_RX_COMPLETE] = rx_irq_enable_r;
        rd_data[`SSP_IRQ_TX_EMPTY] = tx_irq_enable_r;
      end
      `SSP_ADDR_IRQ_PRIORITY: rd_data[7:0] = irq_priority_r;
      `SSP_ADDR_BAUD_DIVISOR: rd_data[7:0] = baud_divisor_r;
      `SSP_ADDR_INT_CONTROL: begin
        rd_data[`SSP_INT_GLOBAL] = global_irq_enable_r;
        rd_data[`SSP_INT_PERIPHERAL] = peripheral_irq_enable_r;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= rd_data;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clock_source_select_r, tx_ninth_bit_enable_r, tx_enable_r, sync_r} <= 4'h0;
      {high_speed_baud_select_r, tx_ninth_bit_value_r} <= 2'h0;
      {port_enable_r, rx_ninth_bit_enable_r, single_rx_enable_r} <= 3'h0;
      {continuous_rx_enable_r, address_detect_enable_r} <= 2'h0;
      {tx_irq_enable_r, rx_irq_enable_r} <= 2'h0;
      {global_irq_enable_r, peripheral_irq_enable_r} <= 2'h0;
      irq_priority_r <= `SSP_RESET_BYTE;
      baud_divisor_r <= `SSP_RESET_BYTE;
    end else if (wr_en) begin
      unique case (paddr)
        `SSP_ADDR_TX_STATUS_CONTROL: begin
          clock_source_select_r <= pwdata[`SSP_TX_CLOCK_SOURCE];
          tx_ninth_bit_enable_r <= pwdata[`SSP_TX_NINTH_EN];
          tx_enable_r <= pwdata[`SSP_TX_ENABLE];
          sync_r <= pwdata[`SSP_TX_SYNC];
          high_speed_baud_select_r <= pwdata[`SSP_TX_HIGH_SPEED];
          tx_ninth_bit_value_r <= pwdata[`SSP_TX_NINTH_VALUE];
        end
        `SSP_ADDR_RX_STATUS_CONTROL: begin
          port_enable_r <= pwdata[`SSP_RX_PORT_ENABLE];
          rx_ninth_bit_enable_r <= pwdata[`SSP_RX_NINTH_EN];
          single_rx_enable_r <= pwdata[`SSP_RX_SINGLE];
          continuous_rx_enable_r <= pwdata[`SSP_RX_CONTINUOUS];
          address_detect_enable_r <= pwdata[`SSP_RX_ADDR_DETECT];
        end
        `SSP_ADDR_IRQ_ENABLES: begin
          rx_irq_enable_r <= pwdata[`SSP_IRQ_RX_COMPLETE];
          tx_irq_enable_r <= pwdata[`SSP_IRQ_TX_EMPTY];
        end
        `SSP_ADDR_IRQ_PRIORITY: irq_priority_r <= pwdata[7:0];
        `SSP_ADDR_BAUD_DIVISOR: baud_divisor_r <= pwdata[7:0];
        `SSP_ADDR_INT_CONTROL: begin
          global_irq_enable_r <= pwdata[`SSP_INT_GLOBAL];
          peripheral_irq_enable_r <= pwdata[`SSP_INT_PERIPHERAL];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers (level changes when 2nd and 3rd agree)
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q_r <= 3'h0;
      dt_q_r <= 3'h7;
      ck_lvl_r <= 1'b0;
      dt_lvl_r <= 1'b1;
    end else begin
      ck_q_r <= {ck_q_r[1:0], link.shift_clock_pin};
      dt_q_r <= {dt_q_r[1:0], link.serial_data_pin};
      if (ck_q_r[1] == ck_q_r[2]) begin
        ck_lvl_r <= ck_q_r[2];
      end
      if (dt_q_r[1] == dt_q_r[2]) begin
        dt_lvl_r <= dt_q_r[2];
      end
    end
  end

  assign ck_fall = ck_lvl_r & (ck_q_r[1] == ck_q_r[2]) & ~ck_q_r[2];
  // Slave only while clock source is external; single receive plays no part
  assign rx_on = port_enable_r & sync_r & ~clock_source_select_r & continuous_rx_enable_r;
  // Half duplex: continuous receive enable inhibits transmit
  assign tx_on = port_enable_r & sync_r & ~clock_source_select_r & tx_enable_r
    & ~continuous_rx_enable_r;
  assign tx_load = tx_on & ~tx_busy_r & tx_buffer_full_r;

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_buffer_r <= `SSP_RESET_BYTE;
      tx_buffer_full_r <= 1'b0;
    end else begin
      if (wr_en && paddr == `SSP_ADDR_TX_BUFFER) begin
        serial_tx_buffer_r <= pwdata[7:0];
        tx_buffer_full_r <= 1'b1;
      end else if (tx_load) begin
        tx_buffer_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty_flag_r <= 1'b0;
    end else if (tx_load) begin
      tx_buffer_empty_flag_r <= 1'b1;
    end else if (wr_en && paddr == `SSP_ADDR_TX_BUFFER) begin
      tx_buffer_empty_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_register_r <= 9'h000;
      tx_cnt_r <= 4'h0;
      tx_busy_r <= 1'b0;
    end else if (!tx_on) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 4'h0;
    end else if (tx_load) begin
      tx_shift_register_r <= {tx_ninth_bit_value_r, serial_tx_buffer_r};
      tx_cnt_r <= 4'h0;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r && ck_fall) begin
      tx_shift_register_r <= {1'b0, tx_shift_register_r[8:1]};
      tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_cnt_r == ssp_pkg::ssp_word_len(tx_ninth_bit_enable_r) - 4'h1) begin
        tx_busy_r <= 1'b0;
      end
    end
  end

  // Clock pin is input only; the data pin is driven only while shifting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.dev_dt_o <= 1'b1;
      link.dev_dt_oe <= 1'b0;
    end else begin
      link.dev_dt_o <= tx_shift_register_r[0];
      link.dev_dt_oe <= tx_busy_r & tx_on;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  assign rx_next = {dt_lvl_r, rx_shift_register_r[8:1]};
  assign rx_done = rx_on & ck_fall
    & (rx_cnt_r == ssp_pkg::ssp_word_len(rx_ninth_bit_enable_r) - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_register_r <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (!rx_on) begin
      rx_cnt_r <= 4'h0;
    end else if (ck_fall) begin
      rx_shift_register_r <= rx_next;
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rx_buffer_r <= `SSP_RESET_BYTE;
      rx_ninth_bit_value_r <= 1'b0;
    end else if (rx_done && !rx_complete_flag_r) begin
      serial_rx_buffer_r <= rx_ninth_bit_enable_r ? rx_next[7:0] : rx_next[8:1];
      rx_ninth_bit_value_r <= rx_ninth_bit_enable_r & rx_next[8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_complete_flag_r <= 1'b0;
    end else if (rx_done) begin
      rx_complete_flag_r <= 1'b1;
    end else if (rd_en && paddr == `SSP_ADDR_RX_BUFFER) begin
      rx_complete_flag_r <= 1'b0;
    end
  end

  // An unread word is kept; the new one is dropped and flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_r <= 1'b0;
    end else if (!continuous_rx_enable_r) begin
      overrun_error_flag_r <= 1'b0;
    end else if (rx_done && rx_complete_flag_r) begin
      overrun_error_flag_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Wake and vector requests
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
      irq_vector_request <= 1'b0;
    end else begin
      wake_request <= low_power_mode & ((tx_irq_enable_r & tx_buffer_empty_flag_r)
        | (rx_irq_enable_r & rx_complete_flag_r));
      irq_vector_request <= global_irq_enable_r & peripheral_irq_enable_r
        & ((tx_irq_enable_r & tx_buffer_empty_flag_r)
        | (rx_irq_enable_r & rx_complete_flag_r));
    end
  end

endmodule

// >>> rtl/ssp_master_end.sv
`timescale 1ns/1ns
`include "ssp_defs.svh"
module ssp_master_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_start,
  input wire logic cmd_send,
  input wire logic cmd_nine,
  input wire logic [8:0] cmd_word,
  output logic busy,
  output logic done,
  output logic [8:0] rx_word,
  ssp_link_if.mst link
);

  ssp_pkg::ssp_mst_state_t state_r;
  logic [8:0] sh_r, rx_r, rx_nxt;
  logic [3:0] bits_r, cnt_r;
  logic [7:0] half_r;
  logic send_r, nine_r, half_end;
  logic [2:0] dt_q_r;
  logic dt_lvl_r;

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_q_r <= 3'h7;
      dt_lvl_r <= 1'b1;
    end else begin
      dt_q_r <= {dt_q_r[1:0], link.serial_data_pin};
      if (dt_q_r[1] == dt_q_r[2]) begin
        dt_lvl_r <= dt_q_r[2];
      end
    end
  end

  // Each clock phase is two link half-periods long, leaving room for the
  // three-flop delay on both ends before the next sampling edge
  assign half_end = (half_r == 8'((2 * `SSP_LINK_HALF_CYC) - 1));
  assign rx_nxt = {dt_lvl_r, rx_r[8:1]};

  // ----------------------------------------
  // Clock generator and shifter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ssp_pkg::SSP_MST_IDLE;
      link.shift_clock_pin <= 1'b0;
      link.mst_dt_o <= 1'b1;
      link.mst_dt_oe <= 1'b0;
      sh_r <= 9'h000;
      rx_r <= 9'h000;
      bits_r <= 4'h8;
      cnt_r <= 4'h0;
      half_r <= 8'h00;
      send_r <= 1'b0;
      nine_r <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_word <= 9'h000;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        ssp_pkg::SSP_MST_IDLE: begin
          if (cmd_start) begin
            state_r <= ssp_pkg::SSP_MST_LOW;
            sh_r <= cmd_word;
            bits_r <= ssp_pkg::ssp_word_len(cmd_nine);
            nine_r <= cmd_nine;
            send_r <= cmd_send;
            link.mst_dt_oe <= cmd_send;
            cnt_r <= 4'h0;
            half_r <= 8'h00;
            busy <= 1'b1;
          end
        end
        ssp_pkg::SSP_MST_LOW: begin
          half_r <= half_end ? 8'h00 : half_r + 8'h01;
          if (half_end) begin
            link.shift_clock_pin <= 1'b1;
            state_r <= ssp_pkg::SSP_MST_HIGH;
            if (send_r) begin
              link.mst_dt_o <= sh_r[0];
              sh_r <= {1'b0, sh_r[8:1]};
            end
          end
        end
        ssp_pkg::SSP_MST_HIGH: begin
          half_r <= half_end ? 8'h00 : half_r + 8'h01;
          if (half_end) begin
            link.shift_clock_pin <= 1'b0;
            rx_r <= rx_nxt;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == bits_r - 4'h1) begin
              state_r <= ssp_pkg::SSP_MST_IDLE;
              link.mst_dt_oe <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              rx_word <= nine_r ? rx_nxt : {1'b0, rx_nxt[8:1]};
            end else begin
              state_r <= ssp_pkg::SSP_MST_LOW;
            end
          end
        end
      endcase
    end
  end

endmodule

// >>> dv/ssp_link_sva.sv
`timescale 1ns/1ns
module ssp_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shift_clock_pin,
  input wire logic dev_dt_o,
  input wire logic dev_dt_oe,
  input wire logic mst_dt_o,
  input wire logic mst_dt_oe,
  input wire logic serial_data_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Link clock shape
  // ----------------------------------------
  ck_high_len_a: assert property (
    $rose(shift_clock_pin) |-> shift_clock_pin[*8] ##8 shift_clock_pin ##1 !shift_clock_pin)
    else $error("shift clock high phase is not 16 cycles");
  ck_low_len_a: assert property (
    $fell(shift_clock_pin) |-> !shift_clock_pin[*8] ##8 !shift_clock_pin)
    else $error("shift clock low phase shorter than 16 cycles");
  // ----------------------------------------
  // Data line ownership and hold
  // ----------------------------------------
  no_contend_a: assert property (!(dev_dt_oe && mst_dt_oe))
    else $error("both ends drive the data line");
  dev_hold_a: assert property (
    shift_clock_pin && $past(shift_clock_pin) && $past(shift_clock_pin, 2) && dev_dt_oe
      && $past(dev_dt_oe) |-> $stable(dev_dt_o))
    else $error("device data moved while shift clock high");
  mst_hold_a: assert property (
    shift_clock_pin && $past(shift_clock_pin) && $past(shift_clock_pin, 2) && mst_dt_oe
      && $past(mst_dt_oe) |-> $stable(mst_dt_o))
    else $error("master data moved before device sampled it");
  oe_start_a: assert property ($rose(dev_dt_oe) |-> !shift_clock_pin)
    else $error("device began driving during a high phase");
  oe_end_a: assert property ($fell(dev_dt_oe) |-> !shift_clock_pin)
    else $error("device released data before the last falling edge");
  mst_release_a: assert property (
    $fell(mst_dt_oe) |-> $fell(shift_clock_pin))
    else $error("master released data away from its last falling edge");
endmodule

// >>> dv/sync_serial_slave_port_tb_top.sv
`timescale 1ns/1ns
module sync_serial_slave_port_tb_top;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic low_power_mode = 0;
  logic cmd_start = 0;
  logic cmd_send = 0;
  logic cmd_nine = 0;
  logic [8:0] cmd_word = 9'h000;
  logic [31:0] prdata;
  logic pready, pslverr, wake_request, irq_vector_request, busy, done;
  logic [8:0] rx_word, w, a, b;
  logic [31:0] q;
  logic e;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 18;

  always #25 pclk = ~pclk;

  ssp_link_if ssp_link_if_i ();
  ssp_slave_dev ssp_slave_dev_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_power_mode(low_power_mode),
    .wake_request(wake_request), .irq_vector_request(irq_vector_request),
    .link(ssp_link_if_i));
  ssp_master_end ssp_master_end_i (.pclk(pclk), .presetn(presetn), .cmd_start(cmd_start),
    .cmd_send(cmd_send), .cmd_nine(cmd_nine), .cmd_word(cmd_word), .busy(busy),
    .done(done), .rx_word(rx_word), .link(ssp_link_if_i));
  ssp_link_sva ssp_link_sva_i (.pclk(pclk), .presetn(presetn),
    .shift_clock_pin(ssp_link_if_i.shift_clock_pin), .dev_dt_o(ssp_link_if_i.dev_dt_o),
    .dev_dt_oe(ssp_link_if_i.dev_dt_oe), .mst_dt_o(ssp_link_if_i.mst_dt_o),
    .mst_dt_oe(ssp_link_if_i.mst_dt_oe), .serial_data_pin(ssp_link_if_i.serial_data_pin));

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic hang(input string nm);
    miscompares++;
    $display("MISMATCH %s expected answer seen none", nm);
    conclude();
  endtask

  // Reads after the edge see the values sampled at that edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang("pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp, input string nm);
    apb(1'b0, ad, 32'h0);
    chk(nm, exp, q);
  endtask

  task automatic xfer(input logic s, input logic n9, input logic [8:0] wd);
    int n;
    cmd_send <= s;
    cmd_nine <= n9;
    cmd_word <= wd;
    cmd_start <= 1'b1;
    @(posedge pclk);
    cmd_start <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n == 1) chk("busy_start", 32'h1, {31'h0, busy});
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) hang("done");
    w = rx_word;
    chk("busy_end", 32'h0, {31'h0, busy});
    // The slave acts on the last clock edge only after its three-flop delay
    repeat (6) @(posedge pclk);
  endtask

  task automatic waitw(input logic exp);
    int n;
    n = 0;
    while (wake_request !== exp && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("wake_request", {31'h0, exp}, {31'h0, wake_request});
  endtask

  // Receive status: stored enables, overrun at bit 1, ninth bit at bit 0
  function automatic logic [31:0] rx_status_exp(input logic [7:0] ctl, input logic r9d,
    input logic ovr);
    return {24'h0, ctl} | {30'h0, ovr, r9d};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h00, 32'h02, "tx_ctl_reset");
    rdc(8'h10, 32'h00, "flags_reset");
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, 8'h00, 32'hff);
    rdc(8'h00, 32'hf7, "tx_ctl_layout");
    $display("test register map done");
    // Two words queued before sleep: second stays buffered
    apb(1'b1, 8'h00, 32'h30);
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h14, 32'h10);
    apb(1'b1, 8'h20, 32'hc0);
    a = 9'($random(seed) & 8'hff);
    b = 9'($random(seed) & 8'hff);
    apb(1'b1, 8'h08, {24'h0, a[7:0]});
    apb(1'b1, 8'h08, {24'h0, b[7:0]});
    // Both words are queued before the chip goes to sleep
    low_power_mode <= 1'b1;
    rdc(8'h10, 32'h00, "tx_empty_held");
    rdc(8'h00, 32'h30, "shift_busy");
    chk("wake_early", 32'h0, {31'h0, wake_request});
    xfer(1'b0, 1'b0, 9'h000);
    chk("first_word", {23'h0, a}, {23'h0, w});
    waitw(1'b1);
    chk("vector", 32'h1, {31'h0, irq_vector_request});
    rdc(8'h10, 32'h10, "tx_empty_set");
    apb(1'b1, 8'h10, 32'h0);
    rdc(8'h10, 32'h10, "tx_empty_sticky");
    xfer(1'b0, 1'b0, 9'h000);
    chk("second_word", {23'h0, b}, {23'h0, w});
    $display("test two-word transmit done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, 32'h70 | 32'(i));
      a = 9'($random(seed) & 8'hff);
      apb(1'b1, 8'h08, {24'h0, a[7:0]});
      xfer(1'b0, 1'b1, 9'h000);
      chk("tx9_word", {23'h0, i[0], a[7:0]}, {23'h0, w});
    end
    apb(1'b1, 8'h14, 32'h20);
    rdc(8'h00, 32'h73, "shift_empty_idle");
    $display("test nine-bit transmit done");
    // Single-receive alone must not receive
    apb(1'b1, 8'h04, 32'ha0);
    xfer(1'b1, 1'b0, 9'h0a5);
    apb(1'b1, 8'h18, 32'h30);
    rdc(8'h10, 32'h10, "single_ignored");
    waitw(1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, i[0] ? 32'hf0 : 32'hb0);
      a = 9'($random(seed));
      xfer(1'b1, i[0], a);
      waitw(1'b1);
      chk("rx_vector", 32'h1, {31'h0, irq_vector_request});
      rdc(8'h10, 32'h30, "rx_flag");
      rdc(8'h04, rx_status_exp(i[0] ? 8'hf0 : 8'hb0, i[0] & a[8], 1'b0), "rx_status");
      rdc(8'h0c, {24'h0, a[7:0]}, "rx_data");
      waitw(1'b0);
    end
    $display("test receive done");
    apb(1'b1, 8'h20, 32'h40);
    // Back to eight-bit words, as the master sends them below
    apb(1'b1, 8'h04, 32'hb0);
    a = 9'($random(seed) & 8'hff);
    b = 9'($random(seed) & 8'hff);
    xfer(1'b1, 1'b0, a);
    waitw(1'b1);
    xfer(1'b1, 1'b0, b);
    chk("vector_masked", 32'h0, {31'h0, irq_vector_request});
    rdc(8'h04, rx_status_exp(8'hb0, 1'b0, 1'b1), "overrun_set");
    rdc(8'h0c, {24'h0, a[7:0]}, "overrun_keeps");
    apb(1'b1, 8'h04, 32'h80);
    rdc(8'h04, 32'h80, "overrun_cleared");
    $display("test overrun done");
    conclude();
  end
endmodule
